// ===== rtl/stc_pkg.sv
// types shared by the standard timer modules
package stc_pkg;

    typedef enum logic [1:0] {
        STC_MODE_CMP  = 2'h0,
        STC_MODE_RSVD = 2'h1,
        STC_MODE_PWM  = 2'h2,
        STC_MODE_TMR  = 2'h3
    } stc_mode_e;

    typedef enum logic [1:0] {
        STC_PIN_NONE   = 2'h0,
        STC_PIN_LOW    = 2'h1,
        STC_PIN_HIGH   = 2'h2,
        STC_PIN_TOGGLE = 2'h3
    } stc_pin_e;

    typedef struct packed {
        logic       pause;
        logic [2:0] clk_sel;
        logic       timer_on;
        logic [2:0] unused;
    } stc_ctrl0_s;

    typedef struct packed {
        stc_mode_e  mode;
        logic [1:0] pin_action;
        logic       output_level_control;
        logic       output_invert;
        logic       duty_period_swap;
        logic       clear_source_select;
    } stc_ctrl1_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_have;
        logic        aw_bad;
        logic [2:0]  aw_idx;
        logic        w_have;
        logic [7:0]  wbyte;
        logic        wlane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } stc_bus_s;

    typedef struct packed {
        stc_bus_s   bus;
        stc_ctrl0_s ctrl0;
        stc_ctrl1_s ctrl1;
        logic [7:0] cmpa_lo;
        logic [7:0] cmpa_hi;
        logic [7:0] cmpp;
        logic [15:0] cnt;
        logic       on_prev;
        logic       flag_a;
        logic       flag_p;
        logic       lvl;
        logic       pin;
        logic       pin_oe;
    } stc_state_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } stc_tick_s;

endpackage : stc_pkg

// ===== rtl/stc_regs.svh
// register offsets, field positions, reset values and tick dividers of the standard timer
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// byte addresses of the register words
`define STC_OFF_CTRL0     32'h0000_0000
`define STC_OFF_CTRL1     32'h0000_0004
`define STC_OFF_CNT_LO    32'h0000_0008
`define STC_OFF_CNT_HI    32'h0000_000C
`define STC_OFF_CMPA_LO   32'h0000_0010
`define STC_OFF_CMPA_HI   32'h0000_0014
`define STC_OFF_CMPP      32'h0000_0018
`define STC_OFF_FLAGS     32'h0000_001C

// field positions in the flag word
`define STC_FLAG_A_BIT    0
`define STC_FLAG_P_BIT    1

// reset values
`define STC_RST_BYTE      8'h00
`define STC_RST_CNT       16'h0000

// counter arithmetic
`define STC_CNT_MAX       16'hFFFF
`define STC_FULL_SPAN     17'h1_0000

// AXI responses
`define STC_RESP_OKAY     2'h0
`define STC_RESP_SLVERR   2'h2

// system clock cycles per counting tick for each clock selection
`define STC_DIV_FSYS4     16'h0004
`define STC_DIV_FSYS      16'h0001
`define STC_DIV_FH16      16'h0010
`define STC_DIV_FH64      16'h0040
`define STC_DIV_FSUB      16'h0100
`define STC_DIV_NONE      16'h0000

// pin-action codes in the waveform modes
`define STC_PWM_INACTIVE  2'h0
`define STC_PWM_ACTIVE    2'h1
`define STC_PWM_WAVE      2'h2
`define STC_PWM_SINGLE    2'h3

`endif

// ===== rtl/stc_tick_gen.sv
// counting-clock tick generator for the standard timer
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_tick_gen
    import stc_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    // tick out
    output logic            tick
);

    stc_tick_s   s_q;
    stc_tick_s   s_d;
    logic [15:0] div;

    always_comb begin
        case (clk_sel)
            3'h0:    div = `STC_DIV_FSYS4;
            3'h1:    div = `STC_DIV_FSYS;
            3'h2:    div = `STC_DIV_FH16;
            3'h3:    div = `STC_DIV_FH64;
            3'h4:    div = `STC_DIV_FSUB;
            3'h5:    div = `STC_DIV_FSUB;
            default: div = `STC_DIV_NONE;
        endcase
    end

    always_comb begin
        s_d      = s_q;
        s_d.tick = run && (div != `STC_DIV_NONE) && (s_q.cnt == div - 16'h0001);
        if (!run || s_d.tick) begin
            s_d.cnt = 16'h0000;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : stc_tick_gen

// ===== rtl/stc_timer.sv
// standard 16-bit timer with compare A/P, PWM and single pulse, AXI4-Lite registers
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_timer
    import stc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // axi4-lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // timer pin and flags
    output logic             timer_output_pin,
    output logic             timer_output_oe,
    output logic             match_a_flag,
    output logic             match_p_flag
);

    stc_state_s  s_q;
    stc_state_s  s_d;
    logic        tick;
    logic        run;

    assign run = s_q.ctrl0.timer_on && !s_q.ctrl0.pause;

    stc_tick_gen u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (run),
        .clk_sel (s_q.ctrl0.clk_sel),
        .tick    (tick)
    );

    always_comb begin
        logic        wr;
        logic        sw_ctrl0;
        logic        rise;
        logic        fall;
        logic        step;
        logic        ovf;
        logic        a_evt;
        logic        p_evt;
        logic        clr;
        logic        set_a;
        logic        set_p;
        logic        hw_off;
        logic        wave;
        logic [15:0] cmpa;
        logic [15:0] nxt;
        logic [16:0] p_span;
        logic [16:0] a_span;
        logic [16:0] per_v;
        logic [16:0] duty_v;
        logic [2:0]  ridx;
        logic [7:0]  rbyte;
        wr       = 1'b0;
        sw_ctrl0 = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        step     = 1'b0;
        ovf      = 1'b0;
        a_evt    = 1'b0;
        p_evt    = 1'b0;
        clr      = 1'b0;
        set_a    = 1'b0;
        set_p    = 1'b0;
        hw_off   = 1'b0;
        wave     = 1'b0;
        cmpa     = {s_q.cmpa_hi, s_q.cmpa_lo};
        nxt      = s_q.cnt + 16'h0001;
        p_span   = 17'h0_0000;
        a_span   = 17'h0_0000;
        per_v    = 17'h0_0000;
        duty_v   = 17'h0_0000;
        ridx     = araddr[4:2];
        rbyte    = `STC_RST_BYTE;
        s_d      = s_q;

        // write address and data are taken in either order
        if (s_q.bus.awready && awvalid) begin
            s_d.bus.aw_have = 1'b1;
            s_d.bus.aw_bad  = |awaddr[31:5];
            s_d.bus.aw_idx  = awaddr[4:2];
        end
        if (s_q.bus.wready && wvalid) begin
            s_d.bus.w_have = 1'b1;
            s_d.bus.wbyte  = wdata[7:0];
            s_d.bus.wlane0 = wstrb[0];
        end
        if (s_q.bus.aw_have && s_q.bus.w_have && !s_q.bus.bvalid) begin
            wr              = 1'b1;
            s_d.bus.aw_have = 1'b0;
            s_d.bus.w_have  = 1'b0;
            s_d.bus.bvalid  = 1'b1;
            s_d.bus.bresp   = s_q.bus.aw_bad ? `STC_RESP_SLVERR : `STC_RESP_OKAY;
        end else if (s_q.bus.bvalid && bready) begin
            s_d.bus.bvalid = 1'b0;
        end
        s_d.bus.awready = !s_d.bus.aw_have && !s_d.bus.bvalid;
        s_d.bus.wready  = !s_d.bus.w_have && !s_d.bus.bvalid;

        // register writes; only byte lane 0 holds data
        if (wr && !s_q.bus.aw_bad && s_q.bus.wlane0) begin
            case ({27'h000_0000, s_q.bus.aw_idx, 2'h0})
                `STC_OFF_CTRL0: begin
                    s_d.ctrl0        = stc_ctrl0_s'(s_q.bus.wbyte);
                    s_d.ctrl0.unused = 3'h0;
                    sw_ctrl0         = 1'b1;
                end
                `STC_OFF_CTRL1:   s_d.ctrl1   = stc_ctrl1_s'(s_q.bus.wbyte);
                `STC_OFF_CMPA_LO: s_d.cmpa_lo = s_q.bus.wbyte;
                `STC_OFF_CMPA_HI: s_d.cmpa_hi = s_q.bus.wbyte;
                `STC_OFF_CMPP:    s_d.cmpp    = s_q.bus.wbyte;
                `STC_OFF_FLAGS: begin
                    // write one to clear
                    if (s_q.bus.wbyte[`STC_FLAG_A_BIT]) begin
                        s_d.flag_a = 1'b0;
                    end
                    if (s_q.bus.wbyte[`STC_FLAG_P_BIT]) begin
                        s_d.flag_p = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // read channel; counter and flags read as live state
        if (s_q.bus.arready && arvalid) begin
            case ({27'h000_0000, ridx, 2'h0})
                `STC_OFF_CTRL0:   rbyte = s_q.ctrl0;
                `STC_OFF_CTRL1:   rbyte = s_q.ctrl1;
                `STC_OFF_CNT_LO:  rbyte = s_q.cnt[7:0];
                `STC_OFF_CNT_HI:  rbyte = s_q.cnt[15:8];
                `STC_OFF_CMPA_LO: rbyte = s_q.cmpa_lo;
                `STC_OFF_CMPA_HI: rbyte = s_q.cmpa_hi;
                `STC_OFF_CMPP:    rbyte = s_q.cmpp;
                `STC_OFF_FLAGS:   rbyte = {6'h00, s_q.flag_p, s_q.flag_a};
                default:          rbyte = `STC_RST_BYTE;
            endcase
            s_d.bus.rvalid = 1'b1;
            s_d.bus.rdata  = (|araddr[31:5]) ? 32'h0000_0000 : {24'h00_0000, rbyte};
            s_d.bus.rresp  = (|araddr[31:5]) ? `STC_RESP_SLVERR : `STC_RESP_OKAY;
        end else if (s_q.bus.rvalid && rready) begin
            s_d.bus.rvalid = 1'b0;
        end
        s_d.bus.arready = !s_d.bus.rvalid;

        // comparators
        rise   = s_q.ctrl0.timer_on && !s_q.on_prev;
        fall   = !s_q.ctrl0.timer_on && s_q.on_prev;
        step   = tick && run;
        ovf    = (s_q.cnt == `STC_CNT_MAX);
        a_evt  = (cmpa != 16'h0000) && (nxt == cmpa);
        p_evt  = (s_q.cmpp != 8'h00) ? (nxt == {s_q.cmpp, 8'h00}) : ovf;
        p_span = (s_q.cmpp == 8'h00) ? `STC_FULL_SPAN : {1'b0, s_q.cmpp, 8'h00};
        a_span = (cmpa == 16'h0000) ? `STC_FULL_SPAN : {1'b0, cmpa};
        s_d.on_prev = s_q.ctrl0.timer_on;

        case (s_q.ctrl1.mode)
            STC_MODE_PWM: begin
                if (s_q.ctrl1.pin_action == `STC_PWM_SINGLE) begin
                    // single pulse: counter wraps, only compare A acts
                    if (step) begin
                        set_a  = a_evt;
                        hw_off = a_evt;
                    end
                end else begin
                    // swap bit decides which comparator clears the counter
                    if (step) begin
                        clr   = s_q.ctrl1.duty_period_swap ?
                                ((cmpa != 16'h0000) ? a_evt : ovf) : p_evt;
                        set_a = a_evt;
                        set_p = p_evt;
                    end
                end
            end
            default: begin
                // compare output, timer/counter and the undefined code share counting
                if (step) begin
                    if (s_q.ctrl1.clear_source_select) begin
                        clr   = a_evt;
                        set_a = a_evt;
                    end else begin
                        clr   = p_evt;
                        set_a = a_evt;
                        set_p = p_evt;
                    end
                end
            end
        endcase

        // counter: zeroed on rise, held when off
        if (rise) begin
            s_d.cnt = `STC_RST_CNT;
        end else if (step) begin
            s_d.cnt = clr ? `STC_RST_CNT : nxt;
        end

        // pin level before inversion
        if (rise) begin
            s_d.lvl = s_q.ctrl1.output_level_control;
        end else begin
            case (s_q.ctrl1.mode)
                STC_MODE_CMP: begin
                    if (set_a) begin
                        case (stc_pin_e'(s_q.ctrl1.pin_action))
                            STC_PIN_LOW:    s_d.lvl = 1'b0;
                            STC_PIN_HIGH:   s_d.lvl = 1'b1;
                            STC_PIN_TOGGLE: s_d.lvl = !s_q.lvl;
                            default:        s_d.lvl = s_q.lvl;
                        endcase
                    end
                end
                STC_MODE_PWM: begin
                    if (s_q.ctrl1.pin_action == `STC_PWM_SINGLE) begin
                        if (hw_off || fall) begin
                            s_d.lvl = !s_q.ctrl1.output_level_control;
                        end
                    end else if (s_q.ctrl0.timer_on) begin
                        per_v  = s_q.ctrl1.duty_period_swap ? a_span : p_span;
                        duty_v = s_q.ctrl1.duty_period_swap ? p_span : {1'b0, cmpa};
                        wave   = ({1'b0, s_q.cnt} < duty_v) || (duty_v >= per_v);
                        case (s_q.ctrl1.pin_action)
                            `STC_PWM_INACTIVE: s_d.lvl = !s_q.ctrl1.output_level_control;
                            `STC_PWM_ACTIVE:   s_d.lvl = s_q.ctrl1.output_level_control;
                            default:           s_d.lvl = wave ? s_q.ctrl1.output_level_control
                                                              : !s_q.ctrl1.output_level_control;
                        endcase
                    end
                end
                default: s_d.lvl = s_q.lvl;
            endcase
        end

        // a compare A stop loses to a software write of the same register
        if (hw_off && !sw_ctrl0) begin
            s_d.ctrl0.timer_on = 1'b0;
        end

        // flags: a set wins over a clear in the same cycle
        if (set_a) begin
            s_d.flag_a = 1'b1;
        end
        if (set_p) begin
            s_d.flag_p = 1'b1;
        end

        // pin driver: released in timer/counter mode, otherwise optionally inverted
        if (s_d.ctrl1.mode == STC_MODE_TMR) begin
            s_d.pin_oe = 1'b0;
            s_d.pin    = 1'b0;
        end else begin
            s_d.pin_oe = 1'b1;
            s_d.pin    = s_d.lvl ^ s_d.ctrl1.output_invert;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign awready          = s_q.bus.awready;
    assign wready           = s_q.bus.wready;
    assign bresp            = s_q.bus.bresp;
    assign bvalid           = s_q.bus.bvalid;
    assign arready          = s_q.bus.arready;
    assign rdata            = s_q.bus.rdata;
    assign rresp            = s_q.bus.rresp;
    assign rvalid           = s_q.bus.rvalid;
    assign timer_output_pin = s_q.pin;
    assign timer_output_oe  = s_q.pin_oe;
    assign match_a_flag     = s_q.flag_a;
    assign match_p_flag     = s_q.flag_p;

endmodule : stc_timer

// ===== tb/stc_timer_properties.sv
// concurrent checks on the standard timer ports
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_timer_properties
    import stc_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    // pin and flags
    input wire logic        timer_output_pin,
    input wire logic        timer_output_oe,
    input wire logic        match_a_flag,
    input wire logic        match_p_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken_s;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rd_taken_s;
        arvalid && arready;
    endsequence

    b_follows_a: assert property (wr_taken_s |-> ##2 bvalid) else $error("no write response after write");
    b_holds_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
    b_refuse_a: assert property (bvalid |-> !awready && !wready) else $error("write accepted during response");
    r_follows_a: assert property (rd_taken_s |=> rvalid) else $error("no read data after read address");
    r_holds_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
    r_byte_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    r_err_zero_a: assert property (rvalid && rresp == `STC_RESP_SLVERR |-> rdata == 32'h0000_0000)
        else $error("error read carries data");
    pin_idle_a: assert property (!timer_output_oe |-> !timer_output_pin) else $error("pin high while not driven");
    flag_a_sticky_a: assert property ($fell(match_a_flag) |-> $rose(bvalid)) else $error("A flag lost");
    flag_p_sticky_a: assert property ($fell(match_p_flag) |-> $rose(bvalid)) else $error("P flag lost");
endmodule : stc_timer_properties

bind stc_timer stc_timer_properties stc_timer_properties_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
);

// ===== tb/testbench.sv
// self-checking testbench of the standard timer
`timescale 1ns/1ps
`include "stc_regs.svh"
`define CHECK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin fail_count++; $display("MISMATCH %0t %s", $time, msg); end end

module testbench
    import stc_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        timer_output_pin, timer_output_oe, match_a_flag, match_p_flag;
    int          fail_count, comparisons, h, g;

    always #5 aclk = ~aclk;

    stc_timer stc_timer_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
        .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

    task automatic axi_write(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p, input logic on);
        axi_write(`STC_OFF_CTRL0, 8'h10, resp);
        axi_write(`STC_OFF_CTRL1, c1, resp);
        axi_write(`STC_OFF_CMPA_LO, a[7:0], resp);
        axi_write(`STC_OFF_CMPA_HI, a[15:8], resp);
        axi_write(`STC_OFF_CMPP, p, resp);
        axi_write(`STC_OFF_FLAGS, 8'h03, resp);
        if (on) axi_write(`STC_OFF_CTRL0, 8'h18, resp);
    endtask : cfg

    task automatic count_high(input int n);
        h = 0;
        repeat (n) begin
            @(posedge aclk);
            h += (timer_output_pin === 1'b1);
        end
    endtask : count_high

    // cycles between the next two pin changes
    task automatic edge_gap();
        logic v;
        @(posedge aclk);
        v = timer_output_pin;
        while (timer_output_pin === v) @(posedge aclk);
        v = timer_output_pin;
        g = 0;
        do begin
            @(posedge aclk);
            g++;
        end while (timer_output_pin === v);
    endtask : edge_gap

    task automatic t_regs();
        logic [31:0] offs [3] = '{`STC_OFF_CMPA_LO, `STC_OFF_CMPA_HI, `STC_OFF_CMPP};
        logic [7:0]  vals [3] = '{8'h5A, 8'hA5, 8'h3C};
        for (int i = 0; i < 3; i++) begin
            axi_read(offs[i], rdv, resp);
            `CHECK(rdv, 32'h0000_0000, "reset value")
            axi_write(offs[i], vals[i], resp);
            axi_read(offs[i], rdv, resp);
            `CHECK(rdv, {24'h00_0000, vals[i]}, "readback")
        end
        axi_write(32'h0000_0020, 8'hFF, resp);
        `CHECK(resp, `STC_RESP_SLVERR, "unmapped write")
        axi_read(32'h0000_0020, rdv, resp);
        `CHECK(resp, `STC_RESP_SLVERR, "unmapped read")
        `CHECK(rdv, 32'h0000_0000, "unmapped read data")
        $display("test regs done");
    endtask : t_regs

    task automatic t_cmp();
        cfg(8'h39, 16'h0140, 8'h01, 1'b1);
        repeat (3) @(posedge aclk);
        `CHECK(timer_output_pin, 1'b1, "initial level")
        `CHECK(timer_output_oe, 1'b1, "pin driven")
        edge_gap();
        `CHECK(g, 320, "A clear period")
        `CHECK(match_a_flag, 1'b1, "A flag")
        `CHECK(match_p_flag, 1'b0, "no P flag")
        axi_write(`STC_OFF_CTRL1, 8'h09, resp);
        g = (timer_output_pin === 1'b1) ? 700 : 0;
        count_high(700);
        `CHECK(h, g, "no pin action")
        axi_write(`STC_OFF_CTRL1, 8'h19, resp);
        repeat (400) @(posedge aclk);
        `CHECK(timer_output_pin, 1'b0, "A match drives low")
        axi_write(`STC_OFF_CTRL1, 8'h29, resp);
        repeat (400) @(posedge aclk);
        `CHECK(timer_output_pin, 1'b1, "A match drives high")
        $display("test compare done");
    endtask : t_cmp

    task automatic t_tmr();
        logic [31:0] rd2;
        cfg(8'hC4, 16'h0003, 8'h01, 1'b1);
        repeat (600) @(posedge aclk);
        `CHECK({match_a_flag, match_p_flag}, 2'h3, "timer flags")
        `CHECK({timer_output_oe, timer_output_pin}, 2'h0, "pin released")
        axi_write(`STC_OFF_CTRL0, 8'h98, resp);
        axi_read(`STC_OFF_CNT_LO, rdv, resp);
        repeat (20) @(posedge aclk);
        axi_read(`STC_OFF_CNT_LO, rd2, resp);
        `CHECK(rd2, rdv, "counter paused")
        axi_write(`STC_OFF_CTRL0, 8'h18, resp);
        axi_write(`STC_OFF_CTRL0, 8'h10, resp);
        axi_read(`STC_OFF_CNT_LO, rdv, resp);
        repeat (20) @(posedge aclk);
        axi_read(`STC_OFF_CNT_LO, rd2, resp);
        `CHECK(rd2, rdv, "counter held")
        $display("test timer done");
    endtask : t_tmr

    task automatic t_pwm();
        logic [7:0]  c1 [6] = '{8'hA8, 8'hAC, 8'hA8, 8'hAB, 8'h98, 8'h88};
        logic [15:0] ca [6] = '{16'h0040, 16'h0040, 16'h0100, 16'h0300, 16'h0040, 16'h0040};
        int          win [6] = '{256, 256, 512, 768, 100, 100};
        int          exp [6] = '{64, 192, 512, 256, 100, 0};
        for (int i = 0; i < 6; i++) begin
            cfg(c1[i], ca[i], 8'h01, 1'b1);
            repeat (300) @(posedge aclk);
            count_high(win[i]);
            `CHECK(h, exp[i], "pwm high cycles")
            `CHECK({match_a_flag, match_p_flag}, 2'h3, "pwm flags")
        end
        $display("test pwm done");
    endtask : t_pwm

    task automatic t_single();
        cfg(8'hB8, 16'h012C, 8'h01, 1'b0);
        fork
            axi_write(`STC_OFF_CTRL0, 8'h18, resp);
            edge_gap();
        join
        `CHECK(g, 300, "pulse width")
        axi_read(`STC_OFF_CTRL0, rdv, resp);
        `CHECK(rdv[3], 1'b0, "on bit cleared")
        `CHECK({match_a_flag, match_p_flag}, 2'h2, "pulse flags")
        $display("test single done");
    endtask : t_single

    task automatic t_ovf();
        cfg(8'hC0, 16'h0000, 8'h00, 1'b1);
        repeat (65000) @(posedge aclk);
        `CHECK(match_p_flag, 1'b0, "early overflow")
        repeat (600) @(posedge aclk);
        `CHECK(match_p_flag, 1'b1, "overflow flag")
        `CHECK(match_a_flag, 1'b0, "no A flag")
        $display("test overflow done");
    endtask : t_ovf

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    initial begin
        #900000;
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        {aclk, awvalid, wvalid, bready, arvalid, rready, fail_count, comparisons} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_cmp();
        t_tmr();
        t_pwm();
        t_single();
        t_ovf();
        summarize();
    end
endmodule : testbench
